// File: rtl/tpo_top.sv
/*
  Time-proportional output block: heat and cool on/off outputs, their
  cycle settings, switching mode, output rate cap and setpoint ramp.
  Assumes every input comes from logic on ref_clk_in; straps are stable
  from reset release on.
*/
module tpo_top #(
  parameter int TICK_CYCLES_P = tpo_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Straps caught after reset, except motor_pot_life_in
  input wire logic heat_is_relay_in,
  input wire logic cool_is_relay_in,
  input wire logic single_point_in,
  input wire logic out1_is_relay_in,
  input wire logic motor_pot_life_in,
  // Output routing
  input wire logic heat_routed_in,
  input wire logic heat_cool_en_in,
  input wire logic cool_routed_in,
  // Cycle settings
  input wire logic heat_base_wr_in,
  input wire logic [1:0] heat_base_in,
  input wire logic heat_len_wr_in,
  input wire logic [6:0] heat_len_in,
  input wire logic cool_base_wr_in,
  input wire logic [1:0] cool_base_in,
  input wire logic cool_len_wr_in,
  input wire logic [6:0] cool_len_in,
  input wire logic mode_wr_in,
  input wire logic mode_in,
  input wire logic [tpo_pkg::RATE_W-1:0] output_rate_cap_in,
  // Manipulated values in tenths of a percent
  input wire logic signed [tpo_pkg::MV_W-1:0] heat_output_value_in,
  input wire logic signed [tpo_pkg::MV_W-1:0] cool_output_value_in,
  // Setpoint ramp
  input wire logic signed [tpo_pkg::MV_W-1:0] sp_target_in,
  input wire logic ramp_std_in,
  input wire logic [1:0] ramp_unit_in,
  input wire logic [tpo_pkg::RATE_W-1:0] setpoint_rise_rate_in,
  input wire logic [tpo_pkg::RATE_W-1:0] setpoint_fall_rate_in,
  // Channel outputs
  output logic heat_pwm_out,
  output logic cool_pwm_out,
  output logic heat_cycle_start_out,
  output logic cool_cycle_start_out,
  output logic signed [tpo_pkg::MV_W-1:0] heat_mv_out,
  output logic signed [tpo_pkg::MV_W-1:0] cool_mv_out,
  // Status
  output tpo_pkg::tpo_cfg_type heat_cfg_out,
  output tpo_pkg::tpo_cfg_type cool_cfg_out,
  output logic cool_avail_out,
  output logic heat_len_refused_out,
  output logic cool_len_refused_out,
  output logic signed [tpo_pkg::MV_W-1:0] setpoint_out,
  output logic ramping_out,
  output logic ready_out
);
  import tpo_pkg::*;

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES_P - 1);

  tpo_state_type state_q, state_d;
  logic [23:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  tpo_cfg_type heat_cfg_q, heat_cfg_d;
  tpo_cfg_type cool_cfg_q, cool_cfg_d;
  logic heat_rel_q, heat_rel_d;
  logic cool_rel_q, cool_rel_d;
  logic heat_ref_q, heat_ref_d;
  logic cool_ref_q, cool_ref_d;
  logic cool_avail_q, cool_avail_d;
  logic signed [MV_W-1:0] sp_q, sp_d;
  logic [ACC_W-1:0] sp_acc_q, sp_acc_d;
  logic ramping_q, ramping_d;
  logic [RATE_W-1:0] cap;
  logic cap_en;
  logic cool_avail;
  logic run;
  logic [RATE_W-1:0] sp_rate;
  logic [ACC_W-1:0] sp_den;
  logic [ACC_W-1:0] sp_acc_t;

  // A cycle length is taken only on the adjustable base and inside the range for the output type.
  function automatic logic len_ok(input logic [6:0] v, input logic relay, input logic [1:0] base);
    logic [6:0] lo;
    lo = relay ? LEN_RELAY_MIN : LEN_OTHER_MIN;
    return (base == BASE_ADJ) && (v >= lo) && (v <= LEN_MAX);
  endfunction : len_ok

  assign run = (state_q == TPO_RUN);

  assign cool_avail = heat_cool_en_in && cool_routed_in;

  // Cap saturates at its top value and is withdrawn in motor pot life mode.
  // Cap enable and limit
  assign cap = (output_rate_cap_in > RATE_MAX) ? RATE_MAX : output_rate_cap_in;
  assign cap_en = (cap != '0) && !motor_pot_life_in;

  // Millisecond time base; it runs freely so both channels share one phase.
  always_comb
  begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 24'h000001;
    if (tick_cnt_q >= TICK_LAST)
    begin
      tick_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // Start-up and settings. Straps cannot load under the asynchronous reset,
  // so defaults are taken in the first clock after release.
  always_comb
  begin
    state_d = state_q;
    heat_cfg_d = heat_cfg_q;
    cool_cfg_d = cool_cfg_q;
    heat_rel_d = heat_rel_q;
    cool_rel_d = cool_rel_q;
    heat_ref_d = 1'b0;
    cool_ref_d = 1'b0;
    cool_avail_d = cool_avail;
    case (state_q)
      TPO_INIT:
      begin
        heat_rel_d = heat_is_relay_in;
        cool_rel_d = cool_is_relay_in;
        heat_cfg_d.len_s = heat_is_relay_in ? LEN_DEF_RELAY : LEN_DEF_OTHER;
        cool_cfg_d.len_s = single_point_in ? LEN_DEF_RELAY : LEN_DEF_OTHER;
        heat_cfg_d.base = BASE_ADJ;
        cool_cfg_d.base = BASE_ADJ;
        heat_cfg_d.life = out1_is_relay_in ? MODE_LIFE : MODE_ACCURACY;
        cool_cfg_d.life = out1_is_relay_in ? MODE_LIFE : MODE_ACCURACY;
        state_d = TPO_RUN;
      end
      TPO_RUN:
      begin
        if (mode_wr_in)
        begin
          heat_cfg_d.life = mode_in;
          cool_cfg_d.life = mode_in;
        end
        if (heat_base_wr_in)
          heat_cfg_d.base = heat_base_in;
        if (heat_len_wr_in)
        begin
          if (len_ok(heat_len_in, heat_rel_q, heat_cfg_q.base))
            heat_cfg_d.len_s = heat_len_in;
          else
            heat_ref_d = 1'b1;
        end
        if (cool_base_wr_in && cool_avail)
          cool_cfg_d.base = cool_base_in;
        if (cool_len_wr_in)
        begin
          if (cool_avail && len_ok(cool_len_in, cool_rel_q, cool_cfg_q.base))
            cool_cfg_d.len_s = cool_len_in;
          else
            cool_ref_d = 1'b1;
        end
      end
      default:
        state_d = TPO_INIT;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= TPO_INIT;
      heat_cfg_q <= CFG_RESET;
      cool_cfg_q <= CFG_RESET;
      heat_rel_q <= 1'b0;
      cool_rel_q <= 1'b0;
      heat_ref_q <= 1'b0;
      cool_ref_q <= 1'b0;
      cool_avail_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      heat_cfg_q <= heat_cfg_d;
      cool_cfg_q <= cool_cfg_d;
      heat_rel_q <= heat_rel_d;
      cool_rel_q <= cool_rel_d;
      heat_ref_q <= heat_ref_d;
      cool_ref_q <= cool_ref_d;
      cool_avail_q <= cool_avail_d;
    end
  end

  // Setpoint ramp. The accumulator gains the rate each tick and pays one
  // tenth of a unit per clock, so even the top rate needs no divider.
  always_comb
  begin
    sp_rate = (sp_target_in > sp_q) ? setpoint_rise_rate_in : setpoint_fall_rate_in;
    case (ramp_unit_in)
      RAMP_PER_S: sp_den = DEN_S;
      RAMP_PER_MIN: sp_den = DEN_MIN;
      default: sp_den = DEN_HOUR;
    endcase
    sp_acc_t = sp_acc_q + (tick_q ? ACC_W'(sp_rate) : '0);
    sp_d = sp_q;
    sp_acc_d = sp_acc_t;
    if (!run || !ramp_std_in || sp_rate == '0 || sp_q == sp_target_in)
    begin
      sp_d = sp_target_in;
      sp_acc_d = '0;
    end
    else if (sp_acc_t >= sp_den)
    begin
      sp_acc_d = sp_acc_t - sp_den;
      sp_d = (sp_target_in > sp_q) ? sp_q + 16'sh0001 : sp_q - 16'sh0001;
    end
    ramping_d = (sp_d != sp_target_in);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sp_q <= '0;
      sp_acc_q <= '0;
      ramping_q <= 1'b0;
    end
    else
    begin
      sp_q <= sp_d;
      sp_acc_q <= sp_acc_d;
      ramping_q <= ramping_d;
    end
  end

  // Heat channel runs whenever its value is routed to a pulse output.
  tpo_chan u_heat (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_q),
    .enable_in(run && heat_routed_in),
    .cfg_in(heat_cfg_q),
    .mv_in(heat_output_value_in),
    .rate_cap_in(cap),
    .cap_en_in(cap_en),
    .pwm_out(heat_pwm_out),
    .cycle_start_out(heat_cycle_start_out),
    .mv_eff_out(heat_mv_out)
  );

  // Cool channel is held off unless heat/cool operation routes it.
  // Cool channel enable
  tpo_chan u_cool (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_q),
    .enable_in(run && cool_avail_q),
    .cfg_in(cool_cfg_q),
    .mv_in(cool_output_value_in),
    .rate_cap_in(cap),
    .cap_en_in(cap_en),
    .pwm_out(cool_pwm_out),
    .cycle_start_out(cool_cycle_start_out),
    .mv_eff_out(cool_mv_out)
  );

  // Status from registers.
  assign heat_cfg_out = heat_cfg_q;
  assign cool_cfg_out = cool_cfg_q;
  assign cool_avail_out = cool_avail_q;
  assign heat_len_refused_out = heat_ref_q;
  assign cool_len_refused_out = cool_ref_q;
  assign setpoint_out = sp_q;
  assign ramping_out = ramping_q;
  assign ready_out = run;

endmodule : tpo_top

// File: rtl/tpo_pkg.sv
/*
  Shared constants and types for the time-proportional output block.
  Assumes a single 10 MHz clock and manipulated values in tenths of a percent.
*/
package tpo_pkg;

  // Clock rate and the millisecond time base derived from it.
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
  localparam int TICKS_PER_S_I = 1_000_000 / TICK_TIME_US;

  // Cycle base codes.
  localparam logic [1:0] BASE_ADJ = 2'h0;
  localparam logic [1:0] BASE_500MS = 2'h1;
  localparam logic [1:0] BASE_250MS = 2'h2;
  localparam logic [1:0] BASE_100MS = 2'h3;

  // Cycle lengths in time base ticks (milliseconds).
  localparam int CYC_W = 17;
  localparam logic [CYC_W-1:0] TICKS_PER_S = CYC_W'(TICKS_PER_S_I);
  localparam logic [CYC_W-1:0] FIX_500_MS = 17'h001f4;
  localparam logic [CYC_W-1:0] FIX_250_MS = 17'h000fa;
  localparam logic [CYC_W-1:0] FIX_100_MS = 17'h00064;

  // Adjustable cycle length limits and defaults in seconds.
  localparam logic [6:0] LEN_RELAY_MIN = 7'h05;
  localparam logic [6:0] LEN_OTHER_MIN = 7'h01;
  localparam logic [6:0] LEN_MAX = 7'h78;
  localparam logic [6:0] LEN_DEF_RELAY = 7'h0a;
  localparam logic [6:0] LEN_DEF_OTHER = 7'h02;

  // Switching modes.
  localparam logic MODE_ACCURACY = 1'b0;
  localparam logic MODE_LIFE = 1'b1;

  // Value widths and scales.
  localparam int MV_W = 16;
  localparam int RATE_W = 14;
  localparam logic signed [MV_W-1:0] MV_FULL = 16'sh03e8;
  localparam logic [RATE_W-1:0] RATE_MAX = 14'h270f;
  localparam logic [9:0] STEP_DEN = 10'h3e8;

  // Setpoint ramp time units and their tick counts.
  localparam logic [1:0] RAMP_PER_S = 2'h0;
  localparam logic [1:0] RAMP_PER_MIN = 2'h1;
  localparam logic [1:0] RAMP_PER_HOUR = 2'h2;
  localparam int ACC_W = 23;
  localparam logic [ACC_W-1:0] DEN_S = ACC_W'(TICKS_PER_S_I);
  localparam logic [ACC_W-1:0] DEN_MIN = ACC_W'(TICKS_PER_S_I * 60);
  localparam logic [ACC_W-1:0] DEN_HOUR = ACC_W'(TICKS_PER_S_I * 3600);

  // Per-channel configuration.
  typedef struct packed {
    logic [1:0] base;
    logic [6:0] len_s;
    logic life;
  } tpo_cfg_type;

  localparam tpo_cfg_type CFG_RESET = '{base: BASE_ADJ, len_s: LEN_DEF_OTHER,
                                         life: MODE_ACCURACY};

  // Start-up sequencing.
  typedef enum logic [0:0] {
    TPO_INIT = 1'b0,
    TPO_RUN = 1'b1
  } tpo_state_type;

endpackage : tpo_pkg

// File: rtl/tpo_chan.sv
/*
  One time-proportional channel: rate limiter on the manipulated value and
  the slow on/off output. Assumes tick_in is a one-clock pulse each millisecond.
*/
module tpo_chan (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Time base and control
  input wire logic tick_in,
  input wire logic enable_in,
  input wire tpo_pkg::tpo_cfg_type cfg_in,
  input wire logic signed [tpo_pkg::MV_W-1:0] mv_in,
  input wire logic [tpo_pkg::RATE_W-1:0] rate_cap_in,
  input wire logic cap_en_in,
  // Results
  output logic pwm_out,
  output logic cycle_start_out,
  output logic signed [tpo_pkg::MV_W-1:0] mv_eff_out
);
  import tpo_pkg::*;

  logic signed [MV_W-1:0] mv_q, mv_d;
  logic [RATE_W+2:0] acc_q, acc_d;
  logic [CYC_W-1:0] cnt_q, cnt_d;
  logic [10:0] held_q, held_d;
  logic pwm_q, pwm_d;
  logic start_q, start_d;
  logic [CYC_W-1:0] cycle_ticks;
  logic [10:0] duty_now, duty;
  logic [RATE_W+2:0] acc_t;
  logic [27:0] on_lhs, on_rhs;

  // Cycle length in ticks from the cycle base.
  // Cycle base decode
  always_comb
  begin
    case (cfg_in.base)
      BASE_ADJ: cycle_ticks = CYC_W'(cfg_in.len_s * TICKS_PER_S);
      BASE_500MS: cycle_ticks = FIX_500_MS;
      BASE_250MS: cycle_ticks = FIX_250_MS;
      default: cycle_ticks = FIX_100_MS;
    endcase
  end

  // Rate limiter, then PWM counter and comparison.
  always_comb
  begin
    mv_d = mv_q;
    acc_t = acc_q + (tick_in ? (RATE_W+3)'(rate_cap_in) : '0);
    acc_d = acc_t;
    if (!cap_en_in)
    begin
      mv_d = mv_in;
      acc_d = '0;
    end
    else if (mv_q == mv_in)
    begin
      acc_d = '0;
    end
    else if (acc_t >= (RATE_W+3)'(STEP_DEN))
    begin
      // One tenth of a percent per clock keeps the step exact and needs no divider.
      acc_d = acc_t - (RATE_W+3)'(STEP_DEN);
      mv_d = (mv_in > mv_q) ? mv_q + 16'sh0001 : mv_q - 16'sh0001;
    end
    if (mv_q < 16'sh0000)
      duty_now = 11'h000;
    else if (mv_q > MV_FULL)
      duty_now = 11'(MV_FULL);
    else
      duty_now = 11'(mv_q);
    cnt_d = cnt_q;
    held_d = held_q;
    start_d = 1'b0;
    if (!enable_in)
    begin
      cnt_d = '0;
      held_d = duty_now;
    end
    else if (tick_in)
    begin
      if (cnt_q + 17'h00001 >= cycle_ticks)
      begin
        cnt_d = '0;
        held_d = duty_now;
        start_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 17'h00001;
    end
    // Life mode holds duty per cycle
    duty = (cfg_in.life == MODE_LIFE) ? held_q : duty_now;
    on_lhs = 28'(cnt_q) * 28'(STEP_DEN);
    on_rhs = 28'(duty) * 28'(cycle_ticks);
    pwm_d = enable_in && (on_lhs < on_rhs);
  end

  // State registers.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mv_q <= '0;
      acc_q <= '0;
      cnt_q <= '0;
      held_q <= '0;
      pwm_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      mv_q <= mv_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      held_q <= held_d;
      pwm_q <= pwm_d;
      start_q <= start_d;
    end
  end

  assign pwm_out = pwm_q;
  assign cycle_start_out = start_q;
  assign mv_eff_out = mv_q;

endmodule : tpo_chan

// File: sim/tpo_top_checker.sv
/*
  Checker for tpo_top: cycle settings, start-up defaults and the rate cap.
  Assumes it is bound into tpo_top and sees only that module's ports.
*/
module tpo_top_checker
  import tpo_pkg::*;
(
  // Clock, reset and straps
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic heat_is_relay_in,
  input wire logic single_point_in,
  input wire logic out1_is_relay_in,
  input wire logic motor_pot_life_in,
  // Settings and values
  input wire logic heat_cool_en_in,
  input wire logic cool_routed_in,
  input wire logic heat_len_wr_in,
  input wire logic [6:0] heat_len_in,
  input wire logic cool_len_wr_in,
  input wire logic [RATE_W-1:0] output_rate_cap_in,
  input wire logic signed [MV_W-1:0] heat_output_value_in,
  // Results
  input wire tpo_cfg_type heat_cfg_out,
  input wire tpo_cfg_type cool_cfg_out,
  input wire logic heat_len_refused_out,
  input wire logic cool_len_refused_out,
  input wire logic signed [MV_W-1:0] heat_mv_out,
  input wire logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Defaults come from the straps once start-up is over.
  heat_default_a: assert property ($rose(ready_out) |->
    heat_cfg_out.len_s == (heat_is_relay_in ? LEN_DEF_RELAY : LEN_DEF_OTHER))
    else $error("heat cycle default wrong");
  cool_default_a: assert property ($rose(ready_out) |->
    cool_cfg_out.len_s == (single_point_in ? LEN_DEF_RELAY : LEN_DEF_OTHER))
    else $error("cool cycle default wrong");
  mode_default_a: assert property ($rose(ready_out) |->
    heat_cfg_out.life == out1_is_relay_in) else $error("mode default wrong");

  // Length writes: refused with a fixed base, out of range or with no cool output.
  fixed_base_a: assert property (ready_out && heat_len_wr_in && heat_cfg_out.base != BASE_ADJ
    |=> heat_len_refused_out && $stable(heat_cfg_out.len_s)) else $error("fixed base len taken");
  relay_range_a: assert property (ready_out && heat_len_wr_in && heat_is_relay_in &&
    (heat_len_in < LEN_RELAY_MIN || heat_len_in > LEN_MAX) |=> heat_len_refused_out)
    else $error("relay range not refused");
  len_accept_a: assert property (ready_out && heat_len_wr_in && heat_cfg_out.base == BASE_ADJ &&
    heat_len_in >= (heat_is_relay_in ? LEN_RELAY_MIN : LEN_OTHER_MIN) && heat_len_in <= LEN_MAX
    |=> heat_cfg_out.len_s == $past(heat_len_in) && !heat_len_refused_out) else $error("len lost");
  cool_closed_a: assert property (ready_out && cool_len_wr_in &&
    !(heat_cool_en_in && cool_routed_in) |=> cool_len_refused_out) else $error("cool len taken");

  // With no cap the value passes straight through, one clock late.
  cap_off_a: assert property (ready_out && $past(ready_out) &&
    (output_rate_cap_in == 0 || motor_pot_life_in) |=> heat_mv_out == $past(heat_output_value_in))
    else $error("uncapped value lags");
endmodule : tpo_top_checker

bind tpo_top tpo_top_checker i_chk (.ref_clk_in, .rst_n_in, .heat_is_relay_in,
  .single_point_in, .out1_is_relay_in, .motor_pot_life_in, .heat_cool_en_in, .cool_routed_in,
  .heat_len_wr_in, .heat_len_in, .cool_len_wr_in, .output_rate_cap_in, .heat_output_value_in,
  .heat_cfg_out, .cool_cfg_out, .heat_len_refused_out, .cool_len_refused_out, .heat_mv_out,
  .ready_out);

// File: sim/tpo_actuator.sv
/*
  Relay model on one time-proportional output: measures each closure and
  counts closures per cycle. Assumes registered drive and start pulses.
*/
module tpo_actuator (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Drive from the block
  input wire logic drive_in,
  input wire logic cycle_start_in,
  // Measurements
  output logic [15:0] on_len_out,
  output logic [3:0] rises_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_q;
  logic [15:0] run_q;
  logic [3:0] cnt_q;
  logic rise;
  assign rise = drive_in && !drive_q;
  // A closure's length is kept when the contact opens; a rise on a start edge counts as the old cycle.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      drive_q <= 1'b0;
      run_q <= 16'h0000;
      cnt_q <= 4'h0;
      on_len_out <= 16'h0000;
      rises_out <= 4'h0;
    end
    else
    begin
      drive_q <= drive_in;
      run_q <= drive_in ? (rise ? 16'h0001 : run_q + 16'h0001) : 16'h0000;
      if (!drive_in && drive_q)
        on_len_out <= run_q;
      cnt_q <= cycle_start_in ? 4'h0 : cnt_q + 4'(rise);
      if (cycle_start_in)
        rises_out <= cnt_q + 4'(rise);
    end
  end
endmodule : tpo_actuator

// File: sim/tpo_top_test.sv
/*
  Self-checking bench for tpo_top with a relay model on the heat output.
  Assumes a 10 MHz clock and a tick of ten clocks, so 0.1 s is 1000 clocks.
*/
module tpo_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tpo_pkg::*;
  logic ref_clk_in, rst_n_in, heat_is_relay_in, cool_is_relay_in, single_point_in;
  logic out1_is_relay_in, motor_pot_life_in, heat_routed_in, heat_cool_en_in, cool_routed_in;
  logic heat_base_wr_in, heat_len_wr_in, cool_base_wr_in, cool_len_wr_in, mode_wr_in, mode_in;
  logic [1:0] heat_base_in, cool_base_in, ramp_unit_in;
  logic [6:0] heat_len_in, cool_len_in;
  logic [RATE_W-1:0] output_rate_cap_in, setpoint_rise_rate_in, setpoint_fall_rate_in;
  logic signed [MV_W-1:0] heat_output_value_in, cool_output_value_in, sp_target_in;
  logic ramp_std_in, heat_pwm_out, cool_pwm_out, heat_cycle_start_out, cool_cycle_start_out;
  logic signed [MV_W-1:0] heat_mv_out, cool_mv_out, setpoint_out;
  tpo_cfg_type heat_cfg_out, cool_cfg_out, c;
  logic cool_avail_out, heat_len_refused_out, cool_len_refused_out, ramping_out, ready_out;
  logic [15:0] on_len;
  logic [3:0] rises;
  logic signed [MV_W-1:0] sp0;
  int n_fail, checked;
  // Rows: channel, base, length written, refusal and length expected.
  typedef struct packed {logic ch; logic [1:0] b; logic [6:0] l; logic rf; logic [6:0] el;} tpo_row_type;
  tpo_row_type rows [11] = '{'{1'b0, 2'h0, 7'h04, 1'b1, 7'h0a}, '{1'b0, 2'h0, 7'h05, 1'b0, 7'h05},
    '{1'b0, 2'h0, 7'h78, 1'b0, 7'h78}, '{1'b0, 2'h0, 7'h79, 1'b1, 7'h78},
    '{1'b0, 2'h1, 7'h1e, 1'b1, 7'h78}, '{1'b0, 2'h2, 7'h1e, 1'b1, 7'h78},
    '{1'b0, 2'h3, 7'h1e, 1'b1, 7'h78}, '{1'b1, 2'h0, 7'h01, 1'b0, 7'h01},
    '{1'b1, 2'h0, 7'h00, 1'b1, 7'h01}, '{1'b1, 2'h3, 7'h07, 1'b1, 7'h01},
    '{1'b1, 2'h0, 7'h78, 1'b0, 7'h78}};

  tpo_top #(.TICK_CYCLES_P(10)) i_dut (.ref_clk_in, .rst_n_in, .heat_is_relay_in,
    .cool_is_relay_in, .single_point_in, .out1_is_relay_in, .motor_pot_life_in, .heat_routed_in,
    .heat_cool_en_in, .cool_routed_in, .heat_base_wr_in, .heat_base_in, .heat_len_wr_in,
    .heat_len_in, .cool_base_wr_in, .cool_base_in, .cool_len_wr_in, .cool_len_in, .mode_wr_in,
    .mode_in, .output_rate_cap_in, .heat_output_value_in, .cool_output_value_in, .sp_target_in,
    .ramp_std_in, .ramp_unit_in, .setpoint_rise_rate_in, .setpoint_fall_rate_in, .heat_pwm_out,
    .cool_pwm_out, .heat_cycle_start_out, .cool_cycle_start_out, .heat_mv_out, .cool_mv_out,
    .heat_cfg_out, .cool_cfg_out, .cool_avail_out, .heat_len_refused_out, .cool_len_refused_out,
    .setpoint_out, .ramping_out, .ready_out);
  tpo_actuator i_act (.clk_in(ref_clk_in), .rst_n_in, .drive_in(heat_pwm_out),
    .cycle_start_in(heat_cycle_start_out), .on_len_out(on_len), .rises_out(rises));

  // Free-running 10 MHz clock.
  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc

  task automatic do_reset;
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    cyc(16);
    rst_n_in <= 1'b1;
    cyc(3);
    #1;
  endtask : do_reset

  // Base write, then length write on the next edge, so the length sees the new base.
  task automatic put(input logic ch, input logic [1:0] b, input logic [6:0] l);
    @(posedge ref_clk_in);
    {heat_base_in, cool_base_in, heat_base_wr_in, cool_base_wr_in} <= {b, b, ~ch, ch};
    @(posedge ref_clk_in);
    {heat_base_wr_in, cool_base_wr_in, heat_len_in, cool_len_in} <= {2'h0, l, l};
    {heat_len_wr_in, cool_len_wr_in} <= {~ch, ch};
    @(posedge ref_clk_in);
    {heat_len_wr_in, cool_len_wr_in} <= 2'h0;
    #1;
    c = ch ? cool_cfg_out : heat_cfg_out;
  endtask : put

  // Waits for a heat cycle start; a missing start counts as a mismatch.
  task automatic wait_start;
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    while (heat_cycle_start_out !== 1'b1 && k < 3000);
    check(k < 3000, "no cycle start");
  endtask : wait_start

  task automatic go(input logic m, input logic signed [MV_W-1:0] v);
    @(posedge ref_clk_in);
    {mode_in, mode_wr_in, heat_output_value_in} <= {m, 1'b1, v};
    @(posedge ref_clk_in);
    mode_wr_in <= 1'b0;
    wait_start;
    wait_start;
  endtask : go

  // The watchdog allows about three times the expected run.
  initial
  begin
    cyc(60000);
    n_fail++;
    close_out;
  end

  initial
  begin
    n_fail = 0;
    checked = 0;
    // Reset is asserted from time zero so no register is ever unknown under the checker.
    {rst_n_in, heat_is_relay_in, cool_is_relay_in, single_point_in, out1_is_relay_in} = 5'h09;
    {motor_pot_life_in, heat_routed_in, heat_cool_en_in, cool_routed_in} = 4'h7;
    {heat_base_wr_in, heat_len_wr_in, cool_base_wr_in, cool_len_wr_in, mode_wr_in} = 5'h00;
    {mode_in, heat_base_in, cool_base_in, ramp_unit_in, heat_len_in, cool_len_in} = 21'h0;
    {output_rate_cap_in, setpoint_rise_rate_in, setpoint_fall_rate_in} = 42'h0;
    {heat_output_value_in, cool_output_value_in, sp_target_in, ramp_std_in} = 49'h0;
    do_reset;
    check(heat_cfg_out.len_s === LEN_DEF_RELAY && cool_cfg_out.len_s === LEN_DEF_OTHER, "dflt");
    check(heat_cfg_out.life === MODE_LIFE, "mode default");
    foreach (rows[i])
    begin
      put(rows[i].ch, rows[i].b, rows[i].l);
      check((rows[i].ch ? cool_len_refused_out : heat_len_refused_out) === rows[i].rf, "refusal");
      check(c.base === rows[i].b && c.len_s === rows[i].el, "cycle setting");
    end
    @(posedge ref_clk_in);
    {heat_cool_en_in, cool_output_value_in} <= {1'b0, 16'sh03e8};
    put(1'b1, 2'h0, 7'h32);
    check(cool_len_refused_out === 1'b1 && c.len_s === 7'h78 && cool_avail_out === 1'b0, "cool");
    // A full-scale cool value must not reach the pin while the cool channel is closed.
    check(cool_pwm_out === 1'b0 && cool_mv_out === 16'sh03e8, "cool held off");
    // Accuracy mode follows a mid-cycle dip, life mode keeps the latched duty.
    for (int m = 0; m < 2; m++)
    begin
      go(m[0], 16'sh01f4);
      check(on_len === 16'h01f4, "on time");
      cyc(300);
      heat_output_value_in <= 16'sh00c8;
      cyc(100);
      heat_output_value_in <= 16'sh0320;
      wait_start;
      // The model files the closing cycle's count one clock after the start pulse.
      cyc(1);
      #1;
      check(m ? (rises === 4'h1 && on_len === 16'h01f4) : rises >= 4'h2, "switch count");
    end
    for (int k = 0; k < 2; k++)
    begin
      go(MODE_ACCURACY, k ? -16'sh0064 : 16'sh04b0);
      wait_start;
      check(rises === 4'h0 && heat_pwm_out === ~k[0], "clamp");
    end
    @(posedge ref_clk_in);
    {output_rate_cap_in, heat_output_value_in} <= {14'h0064, 16'sh0384};
    cyc(5000);
    #1;
    check(heat_mv_out > -16'sh0037 && heat_mv_out < -16'sh002d, "rate cap");
    @(posedge ref_clk_in);
    motor_pot_life_in <= 1'b1;
    {ramp_std_in, setpoint_rise_rate_in, sp_target_in} <= {1'b1, 14'h03e8, 16'sh0064};
    cyc(500);
    #1;
    check(setpoint_out > 16'sh002d && setpoint_out < 16'sh0037 && ramping_out === 1'b1, "ramp");
    check(heat_mv_out === 16'sh0384, "cap off");
    // Per minute, 150 ticks at this rate give exactly two steps while the carried remainder stays under 30000.
    @(posedge ref_clk_in);
    ramp_unit_in <= RAMP_PER_MIN;
    #1;
    sp0 = setpoint_out;
    cyc(1500);
    #1;
    check(setpoint_out - sp0 === 16'sh0002, "ramp per minute");
    @(posedge ref_clk_in);
    sp_target_in <= -16'sh0014;
    cyc(2);
    #1;
    check(setpoint_out === -16'sh0014, "no ramp");
    @(posedge ref_clk_in);
    {heat_is_relay_in, single_point_in, out1_is_relay_in} <= 3'h2;
    do_reset;
    check(heat_cfg_out.len_s === LEN_DEF_OTHER && cool_cfg_out.len_s === LEN_DEF_RELAY, "dflt");
    check(heat_cfg_out.life === MODE_ACCURACY, "mode default");
    put(1'b0, 2'h0, 7'h01);
    check(heat_len_refused_out === 1'b0 && c.len_s === 7'h01, "short len");
    // Opening heat/cool lets the full-scale cool value drive its pin.
    @(posedge ref_clk_in);
    heat_cool_en_in <= 1'b1;
    cyc(3);
    #1;
    check(cool_avail_out === 1'b1 && cool_pwm_out === 1'b1, "cool on");
    close_out;
  end
endmodule : tpo_top_test
